// ==== rtl/seel_pkg.sv ====
// constants and types shared by the sdram ecc error logger
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package seel_pkg;

   // register byte offsets
   localparam logic [7:0]  OFS_ECC_CONTROL  = 8'h00;
   localparam logic [7:0]  OFS_LOG_FIRST    = 8'h04;
   localparam logic [7:0]  OFS_LOG_SECOND   = 8'h08;
   localparam logic [7:0]  OFS_ADDR_FIRST   = 8'h0C;
   localparam logic [7:0]  OFS_ADDR_SECOND  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h14;

   // ecc control fields
   localparam int          CTL_SBE_REPORT   = 0;
   localparam int          CTL_MBE_REPORT   = 1;
   localparam int          CTL_CORRECT      = 2;
   localparam int          CTL_W            = 3;
   localparam logic [2:0]  CTL_RESET        = 3'h0;

   // error log fields
   localparam int          LOG_SYN_LSB      = 0;
   localparam int          LOG_SYN_W        = 8;
   localparam int          LOG_TYPE_BIT     = 8;
   localparam int          LOG_MASTER_LSB   = 16;
   localparam int          LOG_MASTER_W     = 3;
   localparam logic [31:0] LOG_RESET        = 32'h0000_0000;

   // error address fields
   localparam int          ADDR_LSB         = 2;
   localparam logic [31:0] ADDR_RESET       = 32'h0000_0000;

   // interrupt status fields
   localparam int          STAT_FIRST       = 0;
   localparam int          STAT_SECOND      = 1;
   localparam int          STAT_OVERFLOW    = 2;
   localparam int          STAT_W           = 3;
   localparam logic [2:0]  STAT_RESET       = 3'h0;

   // ecc code shape
   localparam int          DATA_W           = 64;
   localparam int          ECC_W            = 8;

   // which log pair takes a new error
   typedef enum logic [1:0] {
      SLOT_FIRST,
      SLOT_SECOND,
      SLOT_NONE
   } seel_slot_type;

endpackage : seel_pkg

// ==== rtl/seel_ecc_decode.sv ====
// secded syndrome decode and single-bit correction of one 64-bit word
`timescale 1ns/10ps
`default_nettype none
module seel_ecc_decode
   import seel_pkg::*;
(
   // raw word from memory
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic [ECC_W-1:0]  i_ecc,
   input  wire logic              i_correct_en,
   // decoded result
   output logic       [DATA_W-1:0] o_data,
   output logic       [ECC_W-1:0]  o_syndrome,
   output logic                    o_single,
   output logic                    o_multi
);

   // hamming position of data bit idx: skips powers of two, starts at 3
   function automatic logic [6:0] seel_pos(input int idx);
      int cnt;
      logic [6:0] res;
      cnt = 0;
      res = 7'h00;
      for (int n = 3; n < 128; n++) begin
         if (((n & (n - 1)) != 0) && (cnt <= idx)) begin
            if (cnt == idx) begin
               res = 7'(n);
            end
            cnt++;
         end
      end
      return res;
   endfunction : seel_pos

   // syndrome, classification and flip of the bad bit
   always_comb begin
      logic [6:0] syn;
      logic       odd;
      logic       hit;
      syn    = i_ecc[6:0];
      odd    = (^i_data) ^ (^i_ecc);
      hit    = 1'b0;
      o_data = i_data;
      for (int i = 0; i < DATA_W; i++) begin
         if (i_data[i]) begin
            syn = syn ^ seel_pos(i);
         end
      end
      for (int i = 0; i < DATA_W; i++) begin
         if (odd && (syn == seel_pos(i))) begin
            hit = 1'b1;
            if (i_correct_en) begin
               o_data[i] = ~i_data[i];
            end
         end
      end
      o_syndrome = {odd, syn};
      // odd parity on a check-bit position leaves the data intact
      o_single   = odd && (hit || ((syn & (syn - 7'h01)) == 7'h00));
      // even parity with a nonzero syndrome, or odd on no legal position
      o_multi    = (!odd && (syn != 7'h00)) || (odd && !o_single);
   end

endmodule : seel_ecc_decode
`default_nettype wire

// ==== rtl/seel_error_logger.sv ====
// ecc check, error log pairs, status and nmi of the sdram controller
`timescale 1ns/10ps
`default_nettype none
module seel_error_logger
   import seel_pkg::*;
#(
   parameter int MASTER_W = 3
)(
   // clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_rst_n,
   // register port
   input  wire logic [7:0]          i_reg_addr,
   input  wire logic [31:0]         i_reg_wdata,
   input  wire logic                i_reg_wr,
   input  wire logic                i_reg_rd,
   output logic      [31:0]         o_reg_rdata,
   // word read back from memory
   input  wire logic                i_chk_valid,
   input  wire logic                i_chk_rmw,
   input  wire logic                i_chk_bus_open,
   input  wire logic [DATA_W-1:0]   i_chk_data,
   input  wire logic [ECC_W-1:0]    i_chk_ecc,
   input  wire logic [31:0]         i_chk_addr,
   input  wire logic [MASTER_W-1:0] i_chk_master,
   // result towards internal bus and write engine
   output logic                     o_rd_valid,
   output logic      [DATA_W-1:0]   o_rd_data,
   output logic                     o_target_abort,
   output logic                     o_rmw_merge,
   output logic                     o_rmw_abort,
   // interrupt to core
   output logic                     o_nmi,
   output logic                     o_nmi_pulse
);

   // the master field is three bits wide; a wider id would not fit
   if (MASTER_W < 1 || MASTER_W > LOG_MASTER_W) begin : g_bad_master_w
      $error("MASTER_W must lie between 1 and 3");
   end

   //////////////////////////////////////////////////////////////////////////
   // registers
   logic [CTL_W-1:0]  ctl_ff;
   logic [STAT_W-1:0] stat_ff;
   logic [STAT_W-1:0] nxt_stat;
   logic [31:0]       log0_ff;
   logic [31:0]       log1_ff;
   logic [31:0]       addr0_ff;
   logic [31:0]       addr1_ff;
   logic [31:0]       rdata_ff;
   logic [DATA_W-1:0] rd_data_ff;
   logic              rd_valid_ff;
   logic              tabort_ff;
   logic              merge_ff;
   logic              rmw_abort_ff;
   logic              nmi_pulse_ff;

   // decoder outputs
   logic [DATA_W-1:0] corr_data;
   logic [ECC_W-1:0]  syndrome;
   logic              err_single;
   logic              err_multi;

   // derived events
   logic              report_en;
   logic              err_any;
   logic              log_evt;
   logic [STAT_W-1:0] clr_mask;
   logic [31:0]       log_word;
   seel_slot_type     slot;

   //////////////////////////////////////////////////////////////////////////
   // syndrome decode of the word on the memory data bus
   seel_ecc_decode u_decode (
      .i_data       (i_chk_data),
      .i_ecc        (i_chk_ecc),
      .i_correct_en (ctl_ff[CTL_CORRECT]),
      .o_data       (corr_data),
      .o_syndrome   (syndrome),
      .o_single     (err_single),
      .o_multi      (err_multi)
   );

   //////////////////////////////////////////////////////////////////////////
   // event decode
   // one reporting bit is enough to report both error kinds
   assign report_en = ctl_ff[CTL_SBE_REPORT] | ctl_ff[CTL_MBE_REPORT];
   assign err_any   = i_chk_valid & (err_single | err_multi);
   // an error is only logged and flagged while reporting is on
   assign log_evt   = err_any & report_en;
   // write-one-to-clear mask from a status write
   assign clr_mask  = (i_reg_wr && (i_reg_addr == OFS_IRQ_STATUS)) ?
                      i_reg_wdata[STAT_W-1:0] : '0;

   // log word: type, master, syndrome
   always_comb begin
      log_word                                     = LOG_RESET;
      log_word[LOG_SYN_LSB +: LOG_SYN_W]           = syndrome;
      log_word[LOG_TYPE_BIT]                       = err_multi;
      log_word[LOG_MASTER_LSB +: LOG_MASTER_W]     =
         LOG_MASTER_W'(i_chk_master);
   end

   // pair selection: a pair is free while its status bit is clear
   always_comb begin
      if (!stat_ff[STAT_FIRST]) begin
         slot = SLOT_FIRST;
      end else if (!stat_ff[STAT_SECOND]) begin
         slot = SLOT_SECOND;
      end else begin
         slot = SLOT_NONE;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // interrupt status: hardware set wins over a software clear
   always_comb begin
      nxt_stat = stat_ff & ~clr_mask;
      if (log_evt) begin
         case (slot)
            SLOT_FIRST:  nxt_stat[STAT_FIRST]    = 1'b1;
            SLOT_SECOND: nxt_stat[STAT_SECOND]   = 1'b1;
            SLOT_NONE:   nxt_stat[STAT_OVERFLOW] = 1'b1;
            default:     nxt_stat                = nxt_stat;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         stat_ff <= STAT_RESET;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   // nmi is a level while any cause stands, plus a pulse per new cause
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         nmi_pulse_ff <= 1'b0;
      end else begin
         nmi_pulse_ff <= |(nxt_stat & ~stat_ff);
      end
   end
   assign o_nmi       = |stat_ff;
   assign o_nmi_pulse = nmi_pulse_ff;

   //////////////////////////////////////////////////////////////////////////
   // log pairs: written only while free, so an uncleared log never changes
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         log0_ff  <= LOG_RESET;
         addr0_ff <= ADDR_RESET;
      end else if (log_evt && slot == SLOT_FIRST) begin
         log0_ff  <= log_word;
         addr0_ff <= {i_chk_addr[31:ADDR_LSB], 2'b00};
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         log1_ff  <= LOG_RESET;
         addr1_ff <= ADDR_RESET;
      end else if (log_evt && slot == SLOT_SECOND) begin
         log1_ff  <= log_word;
         addr1_ff <= {i_chk_addr[31:ADDR_LSB], 2'b00};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // ecc control register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ctl_ff <= CTL_RESET;
      end else if (i_reg_wr && (i_reg_addr == OFS_ECC_CONTROL)) begin
         ctl_ff <= i_reg_wdata[CTL_W-1:0];
      end
   end

   // read data stand for one cycle after the strobe, zero otherwise
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            OFS_ECC_CONTROL: rdata_ff <= {{(32-CTL_W){1'b0}}, ctl_ff};
            OFS_LOG_FIRST:   rdata_ff <= log0_ff;
            OFS_LOG_SECOND:  rdata_ff <= log1_ff;
            OFS_ADDR_FIRST:  rdata_ff <= addr0_ff;
            OFS_ADDR_SECOND: rdata_ff <= addr1_ff;
            OFS_IRQ_STATUS:  rdata_ff <= {{(32-STAT_W){1'b0}}, stat_ff};
            default:         rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end
   assign o_reg_rdata = rdata_ff;

   //////////////////////////////////////////////////////////////////////////
   // datapath actions, independent of logging and reporting
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff  <= '0;
      end else begin
         // a multi-bit read is aborted, never returned; a single-bit read is returned
         rd_valid_ff <= i_chk_valid & ~i_chk_rmw & ~err_multi;
         if (i_chk_valid) begin
            rd_data_ff <= corr_data;
         end
      end
   end

   // multi-bit: abort a read, and a write whose bus cycle is still open
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         tabort_ff <= 1'b0;
      end else begin
         tabort_ff <= i_chk_valid & err_multi &
                      (~i_chk_rmw | i_chk_bus_open);
      end
   end

   // read phase of a narrow write: merge clean or single-bit data, drop multi-bit data
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         merge_ff     <= 1'b0;
         rmw_abort_ff <= 1'b0;
      end else begin
         merge_ff     <= i_chk_valid & i_chk_rmw & ~err_multi;
         rmw_abort_ff <= i_chk_valid & i_chk_rmw & err_multi;
      end
   end

   assign o_rd_valid     = rd_valid_ff;
   assign o_rd_data      = rd_data_ff;
   assign o_target_abort = tabort_ff;
   assign o_rmw_merge    = merge_ff;
   assign o_rmw_abort    = rmw_abort_ff;

   //////////////////////////////////////////////////////////////////////////
   // checks
   a_single_fixed: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chk_valid && err_single && !i_chk_rmw && ctl_ff[CTL_CORRECT])
      |=> (o_rd_valid && o_rd_data == $past(corr_data) && !o_target_abort &&
           $countones(o_rd_data ^ $past(i_chk_data)) == 1))
      else $error("single-bit read not returned corrected");

   a_first_log_type: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && err_single && stat_ff[1:0] == 2'b00)
      |=> (!log0_ff[LOG_TYPE_BIT] && stat_ff[STAT_FIRST]))
      else $error("single-bit error not logged as single in first pair");

   a_log_master: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && slot == SLOT_SECOND)
      |=> (log1_ff[LOG_MASTER_LSB +: LOG_MASTER_W] ==
           LOG_MASTER_W'($past(i_chk_master))))
      else $error("master not recorded in second log");

   a_log_syndrome: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && !stat_ff[STAT_FIRST])
      |=> (log0_ff[LOG_SYN_W-1:0] == $past(syndrome)))
      else $error("syndrome not recorded in first log");

   a_addr_store: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && !stat_ff[STAT_FIRST])
      |=> (addr0_ff[31:2] == $past(i_chk_addr[31:2]) && addr0_ff[1:0] == 2'b00))
      else $error("failing address not recorded");

   a_nmi_level: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (stat_ff != 3'h0) |-> o_nmi)
      else $error("nmi low with status set");

   a_nmi_rise: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && stat_ff == 3'h0) |=> o_nmi_pulse)
      else $error("no nmi pulse on first error");

   a_w1c_clear: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (clr_mask[STAT_SECOND] && !(log_evt && slot == SLOT_SECOND))
      |=> !stat_ff[STAT_SECOND])
      else $error("write of one did not clear status bit 1");

   a_log_hold: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      stat_ff[STAT_FIRST] |=> $stable(log0_ff) && $stable(addr0_ff))
      else $error("first log changed while still uncleared");

   a_overflow_flag: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && stat_ff[1:0] == 2'b11)
      |=> (stat_ff[STAT_OVERFLOW] && $stable(log0_ff) && $stable(log1_ff)))
      else $error("overflow not flagged or full log overwritten");

   a_read_abort: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chk_valid && err_multi && !i_chk_rmw) |=> (o_target_abort && !o_rd_valid))
      else $error("multi-bit read not target-aborted");

   a_rmw_abort: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chk_valid && err_multi && i_chk_rmw) |=> (o_rmw_abort && !o_rmw_merge))
      else $error("multi-bit rmw not aborted");

   a_quiet_disabled: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!report_en && clr_mask == 3'h0) |=> $stable(stat_ff))
      else $error("status set with reporting disabled");

   a_clean_return: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chk_valid && !err_single && !err_multi && !i_chk_rmw)
      |=> (o_rd_valid && o_rd_data == $past(i_chk_data) && !o_target_abort))
      else $error("clean read not returned unchanged");

   a_rmw_merge: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chk_valid && i_chk_rmw && !err_multi)
      |=> (o_rmw_merge && !o_rmw_abort && !o_rd_valid))
      else $error("clean rmw read phase not merged");

   a_second_slot: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (log_evt && stat_ff[1:0] == 2'b01)
      |=> (stat_ff[STAT_SECOND] && $stable(log0_ff) && $stable(addr0_ff)))
      else $error("second error not placed in the free pair");

   a_done_write_kept: assert property (
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_chk_valid && err_multi && i_chk_rmw && !i_chk_bus_open)
      |=> (o_rmw_abort && !o_target_abort))
      else $error("completed write aborted on the bus or written");

   a_reset_values: assert property (
      @(posedge i_core_clk)
      !i_rst_n |=> (stat_ff == STAT_RESET && ctl_ff == CTL_RESET && log0_ff == LOG_RESET))
      else $error("registers not at reset values after reset");

endmodule : seel_error_logger
`default_nettype wire

// ==== tb/seel_mem_model.sv ====
// memory word source standing in for the sdram array and its bus masters
`timescale 1ns/10ps
`default_nettype none
module seel_mem_model
   import seel_pkg::*;
(
   // clock
   input  wire logic              i_core_clk,
   // word towards the checker
   output logic                   o_chk_valid,
   output logic                   o_chk_rmw,
   output logic                   o_chk_bus_open,
   output logic      [DATA_W-1:0] o_chk_data,
   output logic      [ECC_W-1:0]  o_chk_ecc,
   output logic      [31:0]       o_chk_addr,
   output logic      [2:0]        o_chk_master
);
   //////////////////////////////////////////////////////////////////////////////
   // check bits as stored on the original full write, so clean words decode clean
   function automatic logic [ECC_W-1:0] gen_ecc(input logic [DATA_W-1:0] d);
      logic [ECC_W-1:0] e;
      int               k;
      e = '0;
      k = 0;
      for (int p = 3; p < 72; p++) if ((p & (p - 1)) != 0) begin
         if (d[k]) e[6:0] ^= p[6:0];
         k++;
      end
      e[7] = ^{d, e[6:0]};
      return e;
   endfunction : gen_ecc

   // array taken as fitted with the recommended drive codes
   // idle lines at time zero
   initial begin
      o_chk_valid    = 1'b0;
      o_chk_rmw      = 1'b0;
      o_chk_bus_open = 1'b0;
      o_chk_data     = '0;
      o_chk_ecc      = '0;
      o_chk_addr     = '0;
      o_chk_master   = '0;
   end

   // one word for one cycle; flip injects the array's bit errors
   task automatic send(input logic rmw, input logic open, input logic [63:0] d,
                       input logic [63:0] flip, input logic [31:0] a, input logic [2:0] m);
      @(posedge i_core_clk);
      o_chk_valid    <= 1'b1;
      o_chk_rmw      <= rmw;
      o_chk_bus_open <= open;
      o_chk_data     <= d ^ flip;
      o_chk_ecc      <= gen_ecc(d);
      o_chk_addr     <= a;
      o_chk_master   <= m;
      @(posedge i_core_clk);
      // released lines show inverted junk, nothing may lean on stale values
      o_chk_valid    <= 1'b0;
      o_chk_rmw      <= ~rmw;
      o_chk_bus_open <= ~open;
      o_chk_data     <= ~(d ^ flip);
      o_chk_ecc      <= ~gen_ecc(d);
      o_chk_addr     <= ~a;
      o_chk_master   <= ~m;
   endtask : send
endmodule : seel_mem_model
`default_nettype wire

// ==== tb/tb_seel_error_logger.sv ====
// self-checking testbench of the sdram ecc error logger
`timescale 1ns/10ps
`default_nettype none
module tb_seel_error_logger
   import seel_pkg::*;
;
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

   // design ports
   logic        i_core_clk;
   logic        i_rst_n;
   logic [7:0]  i_reg_addr;
   logic [31:0] i_reg_wdata;
   logic        i_reg_wr;
   logic        i_reg_rd;
   logic [31:0] o_reg_rdata;
   logic        chk_valid, chk_rmw, chk_open;
   logic [63:0] chk_data, o_rd_data;
   logic [7:0]  chk_ecc;
   logic [31:0] chk_addr;
   logic [2:0]  chk_master;
   logic        o_rd_valid, o_target_abort, o_rmw_merge, o_rmw_abort, o_nmi, o_nmi_pulse;
   // bench model of the registers
   logic [31:0] m_log [2];
   logic [31:0] m_addr [2];
   logic [2:0]  m_stat, m_ctl;
   logic [31:0] seed = 32'h0000_0049;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;

   seel_error_logger u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_chk_valid(chk_valid),
      .i_chk_rmw(chk_rmw), .i_chk_bus_open(chk_open), .i_chk_data(chk_data),
      .i_chk_ecc(chk_ecc), .i_chk_addr(chk_addr), .i_chk_master(chk_master),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_target_abort(o_target_abort),
      .o_rmw_merge(o_rmw_merge), .o_rmw_abort(o_rmw_abort), .o_nmi(o_nmi),
      .o_nmi_pulse(o_nmi_pulse));

   seel_mem_model u_mem (.i_core_clk(i_core_clk), .o_chk_valid(chk_valid),
      .o_chk_rmw(chk_rmw), .o_chk_bus_open(chk_open), .o_chk_data(chk_data),
      .o_chk_ecc(chk_ecc), .o_chk_addr(chk_addr), .o_chk_master(chk_master));

   //////////////////////////////////////////////////////////////////////////////
   // clock, 5 ns period
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   // xorshift source, fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // code position of data bit i, powers of two hold check bits
   function automatic logic [6:0] pos(input int i);
      int k;
      k = 0;
      for (int p = 3; p < 72; p++) if ((p & (p - 1)) != 0) begin
         if (k == i) return p[6:0];
         k++;
      end
      return 7'h00;
   endfunction : pos

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_core_clk);
      i_reg_wr    <= 1'b0;
      if (a == OFS_ECC_CONTROL) m_ctl = d[2:0];
      if (a == OFS_IRQ_STATUS) m_stat &= ~d[2:0];
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_core_clk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_core_clk);
      i_reg_rd   <= 1'b0;
      #1 `CHK(o_reg_rdata, e)
   endtask : rd

   // logs only mean something while their status bit is set
   task automatic regs();
      rd(OFS_ECC_CONTROL, 32'(m_ctl));
      rd(OFS_IRQ_STATUS, 32'(m_stat));
      for (int s = 0; s < 2; s++) if (m_stat[s]) begin
         rd(s ? OFS_LOG_SECOND : OFS_LOG_FIRST, m_log[s]);
         rd(s ? OFS_ADDR_SECOND : OFS_ADDR_FIRST, m_addr[s]);
      end
      `CHK(o_nmi, |m_stat)
   endtask : regs

   // one memory word with the given bit errors, outputs judged against the model
   task automatic xfer(input logic rmw, input logic open, input logic [63:0] flip);
      logic [63:0] d;
      logic [31:0] a, lg;
      logic [2:0]  m, old;
      logic [7:0]  syn;
      logic        multi;
      d = {rnd(), rnd()};
      a = rnd() & 32'hFFFF_FFFC;
      m = 3'(rnd());
      syn = 8'h00;
      for (int i = 0; i < 64; i++) if (flip[i]) syn[6:0] ^= pos(i);
      syn[7] = ^flip;
      multi = |flip && !syn[7];
      old = m_stat;
      lg = 32'h0000_0000;
      lg[18:16] = m;
      lg[8] = multi;
      lg[7:0] = syn;
      if (|flip && |m_ctl[1:0]) begin
         if (!m_stat[0]) begin
            m_stat[0] = 1'b1;
            m_log[0] = lg;
            m_addr[0] = a;
         end else if (!m_stat[1]) begin
            m_stat[1] = 1'b1;
            m_log[1] = lg;
            m_addr[1] = a;
         end else m_stat[2] = 1'b1;
      end
      u_mem.send(rmw, open, d, flip, a, m);
      #1 `CHK(o_rd_valid, !rmw && !multi)
      `CHK(o_target_abort, multi && (!rmw || open))
      `CHK(o_rmw_merge, rmw && !multi)
      `CHK(o_rmw_abort, rmw && multi)
      if (!multi) `CHK(o_rd_data, m_ctl[CTL_CORRECT] ? d : d ^ flip)
      `CHK(o_nmi, |m_stat)
      // the pulse rises with the status bit and stands one cycle only
      `CHK(o_nmi_pulse, |(m_stat & ~old))
      @(posedge i_core_clk);
      #1 `CHK(o_nmi_pulse, 1'b0)
   endtask : xfer

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude

   // hang guard, far above the few thousand cycles needed
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic [63:0] fl;
      logic [5:0]  fb;
      i_rst_n = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 32'h0000_0000;
      m_ctl = 3'h0;
      m_stat = 3'h0;
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      // software touches the registers only after reset is released
      wr(OFS_LOG_FIRST, 32'hFFFF_FFFF);
      wr(OFS_ADDR_SECOND, 32'hFFFF_FFFF);
      for (int o = 0; o <= 8'h18; o += 4) rd(o[7:0], 32'h0000_0000);
      // reporting off: actions still happen, nothing logged
      xfer(1'b0, 1'b0, 64'h1);
      xfer(1'b0, 1'b0, 64'h3);
      regs();
      // single-bit report bit alone enables multi-bit reporting too
      wr(OFS_ECC_CONTROL, 32'h0000_0005);
      xfer(1'b0, 1'b0, 64'h1 << 63);
      xfer(1'b1, 1'b1, 64'h11);
      xfer(1'b1, 1'b0, 64'h0000_0100_0000_0020);
      xfer(1'b0, 1'b0, 64'h0);
      regs();
      wr(OFS_IRQ_STATUS, 32'h0000_0001);
      xfer(1'b0, 1'b0, 64'h100);
      regs();
      wr(OFS_IRQ_STATUS, 32'h0000_0007);
      wr(OFS_ECC_CONTROL, 32'h0000_0002);
      xfer(1'b1, 1'b0, 64'h4);
      regs();
      // random mix of errors, control changes and clears
      for (int it = 0; it < 120; it++) begin
         r = rnd();
         if (r[2:0] == 3'h0) wr(OFS_ECC_CONTROL, rnd());
         if (r[5:3] == 3'h0) wr(OFS_IRQ_STATUS, rnd());
         fb = r[13:8] + 6'(r[19:14] % 6'd63 + 6'd1);
         fl = (r[7:6] == 2'h0) ? 64'h0 : 64'h1 << r[13:8];
         if (r[7:6] == 2'h3) fl |= 64'h1 << fb;
         xfer(r[20], r[21], fl);
         regs();
      end
      conclude();
   end
endmodule : tb_seel_error_logger
`default_nettype wire
